// >>> rtl/fcr_regs.svh
// Constants of the field current reference supervisor
`ifndef FCR_REGS_SVH
`define FCR_REGS_SVH

`define FCR_LVL_W         12
`define FCR_LVL_MAX       12'hFFF
`define FCR_LVL_ZERO      12'h000
`define FCR_TMR_ZERO      16'h0000
`define FCR_TMR_ONE       16'h0001
`define FCR_TMR_MAX       16'hFFFF
`define FCR_PCT_SHIFT     8
`define FCR_CANCEL_PCT    19'h00042
`define FCR_PCT_FULL      19'h00064
`define FCR_FALLBACK_VARM 2'h2
`define FCR_AUTOTUNE_RXI  4'h3
`define FCR_FB_ARMATURE   2'h0
`define FCR_FB_TACHO      2'h1
`define FCR_FB_ENCODER    2'h2
`define FCR_CLK_NS        20
`define FCR_MS_NS         1000000
`define FCR_MS_CYCLES     ((`FCR_MS_NS) / (`FCR_CLK_NS))
`define FCR_LOOP_CYCLES   8'h63
`define FCR_WEAK_STEP     12'h001
`define FCR_ALM_UNDER     0
`define FCR_ALM_OVERV     1
`define FCR_ALM_FBFAIL    2
`define FCR_ALM_N         3

`endif

// >>> rtl/fcr_pkg.sv
// Types of the field current reference supervisor
package fcr_pkg;
	typedef logic [11:0] fcr_level_t;
	typedef logic [15:0] fcr_time_t;
	typedef enum logic [2:0] {
		FCR_IDLE,
		FCR_FORCING,
		FCR_RUN,
		FCR_ECO_WAIT,
		FCR_ECONOMY
	} fcr_state_e;
endpackage : fcr_pkg

// >>> rtl/fcr_weak_if.sv
// Link between the supervisor and its back-EMF weakening loop
`timescale 1ns/1ps
interface fcr_weak_if;
	logic              enable;
	fcr_pkg::fcr_level_t emf_est;
	fcr_pkg::fcr_level_t emf_nom;
	fcr_pkg::fcr_level_t nominal;
	logic              at_floor;
	fcr_pkg::fcr_level_t weak_level;
	logic              want_down;

	modport ctrl (output enable, output emf_est, output emf_nom, output nominal, output at_floor,
		input weak_level, input want_down);
	modport loop (input enable, input emf_est, input emf_nom, input nominal, input at_floor,
		output weak_level, output want_down);
endinterface : fcr_weak_if

// >>> rtl/fcr_weak_loop.sv
// Back-EMF field weakening loop
`timescale 1ns/1ps
`include "fcr_regs.svh"
module fcr_weak_loop (
	input  wire logic sys_clk,
	input  wire logic rst_b,
	fcr_weak_if.loop  w
);
	logic [7:0]          tick_cnt_r;
	fcr_pkg::fcr_level_t weak_r;
	fcr_pkg::fcr_level_t weak_nxt;
	logic                want_r;

	wire tick     = (tick_cnt_r == `FCR_LOOP_CYCLES);
	wire emf_high = w.emf_est > w.emf_nom;
	wire can_up   = weak_r < w.nominal;
	wire go_up    = w.enable && emf_high && !w.at_floor && can_up;
	wire go_down  = (!w.enable || !emf_high) && (weak_r != `FCR_LVL_ZERO);

	// Field drops only while estimated EMF is above nominal
	assign weak_nxt = go_up   ? weak_r + `FCR_WEAK_STEP :
	                  go_down ? weak_r - `FCR_WEAK_STEP : weak_r;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tick_cnt_r <= 8'h00;
			weak_r     <= `FCR_LVL_ZERO;
			want_r     <= 1'b0;
		end else begin
			tick_cnt_r <= tick ? 8'h00 : tick_cnt_r + 8'h01;
			if (tick) begin
				weak_r <= weak_nxt;
				want_r <= w.enable && emf_high && w.at_floor;
			end
		end
	end

	assign w.weak_level = weak_r;
	assign w.want_down  = want_r;
endmodule : fcr_weak_loop

// >>> rtl/fcr_supervisor.sv
// Field current reference supervisor top
`timescale 1ns/1ps
`include "fcr_regs.svh"
module fcr_supervisor #(
	parameter int unsigned MS_CYCLES = `FCR_MS_CYCLES
) (
	input  wire logic                sys_clk,
	input  wire logic                rst_b,
	input  wire logic                run_cmd,
	input  wire fcr_pkg::fcr_level_t speed_ref,
	input  wire fcr_pkg::fcr_level_t speed_meas,
	input  wire fcr_pkg::fcr_level_t varm_meas,
	input  wire fcr_pkg::fcr_level_t iarm_meas,
	input  wire fcr_pkg::fcr_level_t nominal_field_setpoint,
	input  wire logic                forcing_enable,
	input  wire logic [7:0]          forcing_percentage,
	input  wire fcr_pkg::fcr_time_t  forcing_duration,
	input  wire logic                economy_enable,
	input  wire logic [7:0]          economy_percentage,
	input  wire fcr_pkg::fcr_time_t  economy_delay,
	input  wire fcr_pkg::fcr_level_t minimum_field_limit,
	input  wire fcr_pkg::fcr_level_t min_rotation_speed,
	input  wire logic                weakening_enable,
	input  wire fcr_pkg::fcr_level_t weakening_start_speed,
	input  wire fcr_pkg::fcr_level_t nominal_mains_voltage,
	input  wire fcr_pkg::fcr_level_t nominal_armature_voltage,
	input  wire fcr_pkg::fcr_level_t max_armature_voltage,
	input  wire logic [1:0]          feedback_select,
	input  wire logic                feedback_fail,
	input  wire logic [1:0]          feedback_fallback_select,
	input  wire logic [3:0]          autotune_selector,
	input  wire logic                autotune_start,
	input  wire logic                alarm_reset,
	output fcr_pkg::fcr_level_t      field_reference_monitor,
	output fcr_pkg::fcr_level_t      armature_voltage_limit,
	output fcr_pkg::fcr_level_t      nominal_emf,
	output logic                     forcing_active,
	output logic                     economy_active,
	output logic                     weakening_active,
	output logic                     armature_feedback_active,
	output logic                     autotune_done,
	output logic                     field_underlimit_alarm,
	output logic                     armature_overvoltage_alarm,
	output logic                     feedback_fail_alarm,
	output logic                     drive_lock
);
	fcr_weak_if wk ();

	// Saturating add and subtract helpers, and scaling helper
	function automatic fcr_pkg::fcr_level_t fcr_sub(input fcr_pkg::fcr_level_t a, input fcr_pkg::fcr_level_t b);
		fcr_sub = (a > b) ? a - b : `FCR_LVL_ZERO;
	endfunction : fcr_sub

	function automatic fcr_pkg::fcr_level_t fcr_add(input fcr_pkg::fcr_level_t a, input fcr_pkg::fcr_level_t b);
		logic [12:0] s;
		s = {1'b0, a} + {1'b0, b};
		fcr_add = s[12] ? `FCR_LVL_MAX : s[11:0];
	endfunction : fcr_add

	function automatic fcr_pkg::fcr_level_t fcr_pct(input fcr_pkg::fcr_level_t a, input logic [7:0] p);
		logic [19:0] m;
		m = a * p;
		fcr_pct = m[19:`FCR_PCT_SHIFT];
	endfunction : fcr_pct

	fcr_pkg::fcr_state_e state_r;
	fcr_pkg::fcr_state_e state_nxt;
	logic                run_d_r;
	logic [15:0]         ms_cnt_r;
	fcr_pkg::fcr_time_t  tmr_r;
	fcr_pkg::fcr_level_t drop_r;
	logic                tune_done_r;
	logic                fb_arm_r;
	logic [`FCR_ALM_N-1:0] alarm_r;
	logic [`FCR_ALM_N-1:0] alarm_set;
	logic                lock_r;
	fcr_pkg::fcr_level_t ref_r;
	fcr_pkg::fcr_level_t vlim_r;
	fcr_pkg::fcr_level_t emf_nom_r;
	logic                forcing_r;
	logic                economy_r;
	logic                weak_act_r;

	// Millisecond tick and state timer
	wire ms_tick   = (ms_cnt_r == 16'(MS_CYCLES - 1));
	wire run_rise  = run_cmd && !run_d_r;
	wire run_fall  = !run_cmd && run_d_r;
	wire tmr_frc   = (tmr_r >= forcing_duration);
	wire tmr_eco   = (tmr_r >= economy_delay);
	wire state_chg = (state_nxt != state_r);

	// Forcing cancel at 66% of mains rating
	wire [18:0] varm_scaled  = 19'(varm_meas) * `FCR_PCT_FULL;
	wire [18:0] mains_scaled = 19'(nominal_mains_voltage) * `FCR_CANCEL_PCT;
	wire        frc_cancel   = varm_scaled >= mains_scaled;
	wire        frc_end      = tmr_frc || frc_cancel || !forcing_enable;

	// Motor turning while stopped
	wire rotating = !run_cmd && (speed_meas >= min_rotation_speed);

	// Next state of the forcing / economy sequencer
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			fcr_pkg::FCR_IDLE,
			fcr_pkg::FCR_ECONOMY: begin
				if (run_rise)
					state_nxt = forcing_enable ? fcr_pkg::FCR_FORCING : fcr_pkg::FCR_RUN;
			end
			fcr_pkg::FCR_FORCING: begin
				if (!run_cmd)
					state_nxt = economy_enable ? fcr_pkg::FCR_ECO_WAIT : fcr_pkg::FCR_IDLE;
				else if (frc_end)
					state_nxt = fcr_pkg::FCR_RUN;
			end
			fcr_pkg::FCR_RUN: begin
				if (run_fall || !run_cmd)
					state_nxt = economy_enable ? fcr_pkg::FCR_ECO_WAIT : fcr_pkg::FCR_IDLE;
			end
			fcr_pkg::FCR_ECO_WAIT: begin
				if (run_rise)
					state_nxt = forcing_enable ? fcr_pkg::FCR_FORCING : fcr_pkg::FCR_RUN;
				else if (!economy_enable)
					state_nxt = fcr_pkg::FCR_IDLE;
				else if (tmr_eco)
					state_nxt = fcr_pkg::FCR_ECONOMY;
			end
			default: state_nxt = fcr_pkg::FCR_IDLE;
		endcase
	end

	wire in_forcing = (state_r == fcr_pkg::FCR_FORCING);
	wire eco_state  = (state_r == fcr_pkg::FCR_ECONOMY);
	wire eco_apply  = eco_state && economy_enable && !run_cmd && !rotating;

	// Feedback source and weakening permission
	wire fb_speed  = (feedback_select == `FCR_FB_TACHO) || (feedback_select == `FCR_FB_ENCODER);
	wire fb_switch = feedback_fail && (feedback_fallback_select == `FCR_FALLBACK_VARM);
	wire weak_ok   = weakening_enable && fb_speed && !fb_arm_r;

	// Autotune of resistive drop and nominal back-EMF
	wire tune_sel  = (autotune_selector == `FCR_AUTOTUNE_RXI);
	wire tune_go   = autotune_start && tune_sel && !run_cmd;
	wire [23:0] drop_prod = drop_r * iarm_meas;
	wire fcr_pkg::fcr_level_t drop_term = drop_prod[23:12];
	wire fcr_pkg::fcr_level_t emf_est  = fcr_sub(varm_meas, drop_term);
	wire fcr_pkg::fcr_level_t emf_nom  = fcr_sub(nominal_armature_voltage, drop_r);

	// Reference build: weakening, forcing or economy, then clamp
	wire fcr_pkg::fcr_level_t base_ref =
		weak_ok ? fcr_sub(nominal_field_setpoint, wk.weak_level) : nominal_field_setpoint;
	wire fcr_pkg::fcr_level_t boost    = fcr_pct(base_ref, forcing_percentage);
	wire fcr_pkg::fcr_level_t cut      = fcr_pct(base_ref, economy_percentage);
	wire fcr_pkg::fcr_level_t adj_ref  =
		in_forcing ? fcr_add(base_ref, boost) :
		eco_apply  ? fcr_sub(base_ref, cut) : base_ref;
	wire below_floor = run_cmd && (adj_ref <= minimum_field_limit);
	wire floor_hit   = run_cmd && (adj_ref < minimum_field_limit);
	wire fcr_pkg::fcr_level_t fin_ref  =
		floor_hit ? minimum_field_limit : adj_ref;

	// Loop connection
	assign wk.enable   = weak_ok && run_cmd && (speed_ref >= weakening_start_speed);
	assign wk.emf_est  = emf_est;
	assign wk.emf_nom  = emf_nom;
	assign wk.nominal  = nominal_field_setpoint;
	assign wk.at_floor = below_floor;

	fcr_weak_loop u_loop (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.w       (wk.loop)
	);

	// Alarm sources
	assign alarm_set[`FCR_ALM_UNDER]  = wk.want_down && run_cmd;
	assign alarm_set[`FCR_ALM_OVERV]  = varm_meas > max_armature_voltage;
	assign alarm_set[`FCR_ALM_FBFAIL] = feedback_fail && !fb_switch;
	wire   lock_nxt = (|alarm_set) || ((|alarm_r) && !alarm_reset);

	// Sticky alarms, set wins over reset
	genvar gi;
	generate
		for (gi = 0; gi < `FCR_ALM_N; gi++) begin : g_alarm
			always_ff @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b)
					alarm_r[gi] <= 1'b0;
				else
					alarm_r[gi] <= alarm_set[gi] || (alarm_r[gi] && !alarm_reset);
			end
		end
	endgenerate

	// Sequencer and edge memory
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= fcr_pkg::FCR_IDLE;
			run_d_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			run_d_r <= run_cmd;
		end
	end

	// Millisecond prescaler and state timer, restart on state change
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ms_cnt_r <= `FCR_TMR_ZERO;
			tmr_r    <= `FCR_TMR_ZERO;
		end else begin
			ms_cnt_r <= (ms_tick || state_chg) ? `FCR_TMR_ZERO : ms_cnt_r + `FCR_TMR_ONE;
			if (state_chg)
				tmr_r <= `FCR_TMR_ZERO;
			else if (ms_tick && tmr_r != `FCR_TMR_MAX)
				tmr_r <= tmr_r + `FCR_TMR_ONE;
		end
	end

	// Autotune result
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			drop_r      <= `FCR_LVL_ZERO;
			tune_done_r <= 1'b0;
		end else if (tune_go) begin
			drop_r      <= varm_meas;
			tune_done_r <= 1'b1;
		end
	end

	// Feedback fallback latch, switch wins over reset
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			fb_arm_r <= 1'b0;
		else if (fb_switch)
			fb_arm_r <= 1'b1;
		else if (alarm_reset && !feedback_fail)
			fb_arm_r <= 1'b0;
	end

	// Registered reference and limits
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ref_r     <= `FCR_LVL_ZERO;
			vlim_r    <= `FCR_LVL_ZERO;
			emf_nom_r <= `FCR_LVL_ZERO;
		end else begin
			ref_r     <= fin_ref;
			vlim_r    <= max_armature_voltage;
			emf_nom_r <= emf_nom;
		end
	end

	// Registered status flags
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			forcing_r  <= 1'b0;
			economy_r  <= 1'b0;
			weak_act_r <= 1'b0;
		end else begin
			forcing_r  <= in_forcing;
			economy_r  <= eco_apply;
			weak_act_r <= wk.enable;
		end
	end

	// Drive lock, set wins over reset
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			lock_r <= 1'b0;
		else
			lock_r <= lock_nxt;
	end

	assign field_reference_monitor    = ref_r;
	assign armature_voltage_limit     = vlim_r;
	assign nominal_emf                = emf_nom_r;
	assign forcing_active             = forcing_r;
	assign economy_active             = economy_r;
	assign weakening_active           = weak_act_r;
	assign armature_feedback_active   = fb_arm_r;
	assign autotune_done              = tune_done_r;
	assign field_underlimit_alarm     = alarm_r[`FCR_ALM_UNDER];
	assign armature_overvoltage_alarm = alarm_r[`FCR_ALM_OVERV];
	assign feedback_fail_alarm        = alarm_r[`FCR_ALM_FBFAIL];
	assign drive_lock                 = lock_r;
endmodule : fcr_supervisor

// >>> sim/fcr_sup_properties.sv
// Checker for the field current reference supervisor ports
`timescale 1ns/1ps
module fcr_sup_properties #(
	parameter int unsigned MS_CYCLES = 4
) (
	input wire logic                sys_clk,
	input wire logic                rst_b,
	input wire logic                run_cmd,
	input wire fcr_pkg::fcr_level_t varm_meas,
	input wire fcr_pkg::fcr_level_t nominal_field_setpoint,
	input wire logic                forcing_enable,
	input wire fcr_pkg::fcr_time_t  forcing_duration,
	input wire fcr_pkg::fcr_level_t minimum_field_limit,
	input wire fcr_pkg::fcr_level_t nominal_mains_voltage,
	input wire fcr_pkg::fcr_level_t max_armature_voltage,
	input wire logic                feedback_fail,
	input wire logic [1:0]          feedback_fallback_select,
	input wire fcr_pkg::fcr_level_t field_reference_monitor,
	input wire fcr_pkg::fcr_level_t armature_voltage_limit,
	input wire logic                forcing_active,
	input wire logic                economy_active,
	input wire logic                weakening_active,
	input wire logic                armature_feedback_active,
	input wire logic                field_underlimit_alarm,
	input wire logic                armature_overvoltage_alarm,
	input wire logic                drive_lock
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	wire [31:0] v100 = varm_meas * 32'd100;
	wire [31:0] m66  = nominal_mains_voltage * 32'd66;
	wire        quiet = !run_cmd && !economy_active && !forcing_active && !weakening_active && !drive_lock;

	a_idle_nominal: assert property (quiet[*3] |-> field_reference_monitor == $past(nominal_field_setpoint))
		else $error("idle reference differs from nominal");
	a_force_start: assert property ($rose(run_cmd) && forcing_enable && forcing_duration != 16'h0000 && v100 < m66
		|-> ##2 forcing_active) else $error("forcing not started");
	a_force_cancel: assert property (forcing_active && v100 >= m66 |-> ##[1:3] !forcing_active)
		else $error("forcing not cancelled");
	a_clamp_floor: assert property ($past(run_cmd) && run_cmd && !drive_lock
		|-> field_reference_monitor >= $past(minimum_field_limit)) else $error("reference below floor");
	a_eco_idle: assert property (economy_active |-> !$past(run_cmd) && !$past(run_cmd, 2))
		else $error("economy while running");
	a_vlim_copy: assert property ($past(rst_b) |-> armature_voltage_limit == $past(max_armature_voltage))
		else $error("voltage limit not copied");
	a_fallback_switch: assert property (feedback_fail && feedback_fallback_select == 2'h2
		|-> ##[1:2] armature_feedback_active) else $error("no fallback to armature");
	a_overv_alarm: assert property (varm_meas > max_armature_voltage |-> ##[1:2] armature_overvoltage_alarm)
		else $error("overvoltage alarm missing");
	a_under_lock: assert property (field_underlimit_alarm |-> ##[0:1] drive_lock)
		else $error("underlimit without lock");
	c_forcing: cover property (forcing_active);
	c_economy: cover property (economy_active);
	c_underlimit: cover property ($rose(field_underlimit_alarm));
endmodule : fcr_sup_properties

bind fcr_supervisor fcr_sup_properties #(.MS_CYCLES(MS_CYCLES)) i_props (.sys_clk, .rst_b, .run_cmd,
	.varm_meas, .nominal_field_setpoint, .forcing_enable, .forcing_duration, .minimum_field_limit,
	.nominal_mains_voltage, .max_armature_voltage, .feedback_fail, .feedback_fallback_select,
	.field_reference_monitor, .armature_voltage_limit, .forcing_active, .economy_active, .weakening_active,
	.armature_feedback_active, .field_underlimit_alarm, .armature_overvoltage_alarm, .drive_lock);

// >>> sim/fcr_motor_model.sv
// Model of the armature voltage, armature current and speed measurements
`timescale 1ns/1ps
module fcr_motor_model (
	input  wire logic                sys_clk,
	input  wire logic                rst_b,
	input  wire fcr_pkg::fcr_level_t speed_tgt,
	input  wire fcr_pkg::fcr_level_t varm_tgt,
	output fcr_pkg::fcr_level_t      speed_meas,
	output fcr_pkg::fcr_level_t      varm_meas,
	output fcr_pkg::fcr_level_t      iarm_meas
);
	// Speed and voltage follow the operating point one cycle late, current stays zero
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			speed_meas <= 12'h000;
			varm_meas  <= 12'h000;
			iarm_meas  <= 12'h000;
		end else begin
			speed_meas <= speed_tgt;
			varm_meas  <= varm_tgt;
			iarm_meas  <= 12'h000;
		end
	end
endmodule : fcr_motor_model

// >>> sim/testbench.sv
// Self-checking bench for the field current reference supervisor
`timescale 1ns/1ps
module testbench;
	logic sys_clk, rst_b, run_cmd, forcing_enable, economy_enable, weakening_enable, feedback_fail;
	logic autotune_start, alarm_reset, forcing_active, economy_active, weakening_active, armature_feedback_active;
	logic autotune_done, field_underlimit_alarm, armature_overvoltage_alarm, feedback_fail_alarm, drive_lock;
	fcr_pkg::fcr_level_t speed_ref, speed_meas, varm_meas, iarm_meas, nominal_field_setpoint, minimum_field_limit;
	fcr_pkg::fcr_level_t min_rotation_speed, weakening_start_speed, nominal_mains_voltage, speed_tgt, varm_tgt;
	fcr_pkg::fcr_level_t nominal_armature_voltage, max_armature_voltage, field_reference_monitor;
	fcr_pkg::fcr_level_t armature_voltage_limit, nominal_emf;
	fcr_pkg::fcr_time_t  forcing_duration, economy_delay;
	logic [7:0]          forcing_percentage, economy_percentage;
	logic [1:0]          feedback_select, feedback_fallback_select;
	logic [3:0]          autotune_selector;
	logic [11:0]         cancel_v [2] = '{12'h7EB, 12'h7EC};
	int                  mismatches, samples_checked;

	fcr_supervisor #(.MS_CYCLES(4)) i_dut (.sys_clk, .rst_b, .run_cmd, .speed_ref, .speed_meas, .varm_meas,
		.iarm_meas, .nominal_field_setpoint, .forcing_enable, .forcing_percentage, .forcing_duration,
		.economy_enable, .economy_percentage, .economy_delay, .minimum_field_limit, .min_rotation_speed,
		.weakening_enable, .weakening_start_speed, .nominal_mains_voltage, .nominal_armature_voltage,
		.max_armature_voltage, .feedback_select, .feedback_fail, .feedback_fallback_select, .autotune_selector,
		.autotune_start, .alarm_reset, .field_reference_monitor, .armature_voltage_limit, .nominal_emf,
		.forcing_active, .economy_active, .weakening_active, .armature_feedback_active, .autotune_done,
		.field_underlimit_alarm, .armature_overvoltage_alarm, .feedback_fail_alarm, .drive_lock);
	fcr_motor_model i_motor (.sys_clk, .rst_b, .speed_tgt, .varm_tgt, .speed_meas, .varm_meas, .iarm_meas);

	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : step
	task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_of_test

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	initial begin
		step(6000);
		mismatches++;
		end_of_test();
	end
	initial begin
		{rst_b, run_cmd, economy_enable, weakening_enable, feedback_fail, autotune_start, alarm_reset} = '0;
		{speed_ref, speed_tgt, varm_tgt, autotune_selector, feedback_fallback_select} = '0;
		forcing_enable = 1'b1;
		nominal_field_setpoint = 12'h800;
		forcing_percentage = 8'h40;
		economy_percentage = 8'h80;
		forcing_duration = 16'h0003;
		economy_delay = 16'h0002;
		minimum_field_limit = 12'h100; // Floor kept well below the lowest level reached
		min_rotation_speed = 12'h010;
		weakening_start_speed = 12'h400;
		nominal_mains_voltage = 12'hC00;
		nominal_armature_voltage = 12'h600;
		max_armature_voltage = 12'hFFF;
		feedback_select = 2'h1;
		step(12);
		rst_b <= 1'b1;
		step(4);
		@(negedge sys_clk);
		chk("ref", 12'h800, field_reference_monitor);
		chk("vlim", 12'hFFF, armature_voltage_limit);
		$display("test idle done");
		step(1);
		run_cmd <= 1'b1;
		step(4);
		@(negedge sys_clk);
		chk("ref", 12'hA00, field_reference_monitor);
		chk("force", 12'h001, {11'h000, forcing_active});
		step(24);
		@(negedge sys_clk);
		chk("ref", 12'h800, field_reference_monitor);
		chk("force", 12'h000, {11'h000, forcing_active});
		foreach (cancel_v[i]) begin
			step(1);
			run_cmd <= 1'b0;
			varm_tgt <= cancel_v[i];
			step(4);
			run_cmd <= 1'b1;
			step(8);
			@(negedge sys_clk);
			chk("force", {11'h000, i == 0}, {11'h000, forcing_active});
		end
		$display("test forcing done");
		step(1);
		run_cmd <= 1'b0;
		varm_tgt <= 12'h000;
		economy_enable <= 1'b1;
		step(4);
		@(negedge sys_clk);
		chk("ref", 12'h800, field_reference_monitor);
		step(12);
		@(negedge sys_clk);
		chk("ref", 12'h400, field_reference_monitor);
		chk("eco", 12'h001, {11'h000, economy_active});
		step(1);
		speed_tgt <= 12'h020;
		step(4);
		@(negedge sys_clk);
		chk("ref", 12'h800, field_reference_monitor);
		chk("eco", 12'h000, {11'h000, economy_active});
		$display("test economy done");
		step(1);
		{speed_tgt, economy_enable, forcing_enable} <= '0;
		minimum_field_limit <= 12'h900;
		run_cmd <= 1'b1;
		step(4);
		@(negedge sys_clk);
		chk("ref", 12'h900, field_reference_monitor);
		step(1);
		run_cmd <= 1'b0;
		step(4);
		@(negedge sys_clk);
		chk("ref", 12'h800, field_reference_monitor);
		step(1);
		max_armature_voltage <= 12'h700;
		varm_tgt <= 12'h7FF;
		feedback_fail <= 1'b1;
		step(4);
		@(negedge sys_clk);
		chk("ovolt", 12'h001, {11'h000, armature_overvoltage_alarm});
		chk("fbfail", 12'h001, {11'h000, feedback_fail_alarm});
		chk("armfb", 12'h000, {11'h000, armature_feedback_active});
		step(1);
		feedback_fallback_select <= 2'h2;
		step(4);
		@(negedge sys_clk);
		chk("armfb", 12'h001, {11'h000, armature_feedback_active});
		step(1);
		{feedback_fail, varm_tgt} <= '0;
		max_armature_voltage <= 12'hFFF;
		alarm_reset <= 1'b1;
		step(4);
		alarm_reset <= 1'b0;
		step(2);
		@(negedge sys_clk);
		chk("lock", 12'h000, {11'h000, drive_lock});
		chk("armfb", 12'h000, {11'h000, armature_feedback_active});
		$display("test alarms done");
		step(1);
		autotune_selector <= 4'h3;
		varm_tgt <= 12'h050;
		step(2);
		autotune_start <= 1'b1;
		step(1);
		autotune_start <= 1'b0;
		step(3);
		@(negedge sys_clk);
		chk("tune", 12'h001, {11'h000, autotune_done});
		chk("emf", 12'h5B0, nominal_emf);
		step(1);
		varm_tgt <= 12'h700;
		feedback_select <= 2'h0;
		weakening_enable <= 1'b1;
		speed_ref <= 12'hC00;
		minimum_field_limit <= 12'h7FC;
		run_cmd <= 1'b1;
		step(300);
		@(negedge sys_clk);
		chk("weak", 12'h000, {11'h000, weakening_active});
		chk("ref", 12'h800, field_reference_monitor);
		step(1);
		feedback_select <= 2'h1;
		step(300);
		@(negedge sys_clk);
		chk("weak", 12'h001, {11'h000, weakening_active});
		chk("lowered", 12'h001, {11'h000, field_reference_monitor < 12'h800});
		step(600);
		@(negedge sys_clk);
		chk("under", 12'h001, {11'h000, field_underlimit_alarm});
		chk("lock", 12'h001, {11'h000, drive_lock});
		$display("test weakening done");
		step(1);
		run_cmd <= 1'b0;
		economy_enable <= 1'b1;
		step(12);
		@(negedge sys_clk);
		chk("ref", 12'h3FE, field_reference_monitor);
		chk("eco", 12'h001, {11'h000, economy_active});
		$display("test combined done");
		end_of_test();
	end
endmodule : testbench
